/* File: dru_coupler_model.sv */
// Backplane coupler model: issues one record read at a time.
// Assumes the record answers one cycle after the strobe.
module dru_coupler_model (
  // Clock
  input wire logic clk,
  // Read port
  output logic rd_req,
  output dru_pkg::dru_rd_req_t rd_cmd,
  input wire logic rd_ack,
  input wire dru_pkg::dru_rd_rsp_t rd_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    rd_req = 1'b0;
    rd_cmd = '0;
  end
  // Selector fields go out as given
  task automatic read(input dru_pkg::dru_rd_req_t c,
                      output dru_pkg::dru_rd_rsp_t r);
    int i;
    @(negedge clk);
    rd_req = 1'b1;
    rd_cmd = c;
    @(negedge clk);
    rd_req = 1'b0;
    // Released command shows garbage, not the last value
    rd_cmd = ~c;
    for (i = 0; i < 4; i++)
    begin
      if (rd_ack === 1'b1)
        break;
      @(negedge clk);
    end
    r = rd_rsp;
  endtask
endmodule

/* File: dru_diag_record.sv */
// Diagnostic record, diagnostic interrupt sequencing and fault lamp.
// Fault inputs are synchronous levels; reads come from the backplane
// coupler through record set, object index or subindex selectors.
module dru_diag_record #(
  parameter int CYCLES_PER_US = dru_pkg::TICK_CYCLES,
  parameter int NUM_CH_BYTES = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Parameter setting and live faults
  input wire logic diag_int_enable,
  input wire dru_pkg::dru_fault_t fault_in,
  // Diagnostic interrupt events and fault lamp
  output logic diag_incoming,
  output logic diag_going,
  output logic fault_lamp,
  // Record read port
  input wire logic rd_req,
  input wire dru_pkg::dru_rd_req_t rd_cmd,
  output logic rd_ack,
  output dru_pkg::dru_rd_rsp_t rd_rsp,
  // Free-running ticker
  output logic [dru_pkg::TICKER_W-1:0] ticker
);

  initial
  begin
    if (NUM_CH_BYTES != 8)
      $error("NUM_CH_BYTES must be 8 for this record layout");
  end

  // Ticker
  dru_ticker #(
    .CYCLES_PER_US(CYCLES_PER_US)
  ) u_ticker (
    .clk(clk),
    .nrst(nrst),
    .ticker(ticker)
  );

  dru_pkg::dru_state_t state_r;
  dru_pkg::dru_state_t state_nxt;
  dru_pkg::dru_fault_t flags_r;
  dru_pkg::dru_fault_t flags_nxt;
  logic [31:0] stamp_r;
  logic any_event;
  logic any_flag;
  logic new_fault;
  logic incoming_r;
  logic going_r;
  logic [7:0] summary;
  logic [7:0] internal_b;
  logic [7:0] ch_byte0;
  logic [7:0] chmap;
  logic [7:0] rec_bytes [0:19];
  logic [7:0] rd_data_r;
  logic rd_err_r;
  logic rd_ack_r;

  // Events that may raise a diagnostic interrupt
  always_comb
  begin
    any_event = fault_in.aux_missing | fault_in.buf_overflow
      | fault_in.comm_err | fault_in.param_err
      | fault_in.range_under | fault_in.range_over; // see (RULE5)
  end

  assign any_flag = |flags_r;
  assign new_fault = |(fault_in & ~flags_r);

  // Interrupt sequencing
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      dru_pkg::DRU_IDLE:
      begin
        if (diag_int_enable && any_event)
          state_nxt = dru_pkg::DRU_ACTIVE; // see (RULE1)
      end
      dru_pkg::DRU_ACTIVE:
      begin
        if (!any_event)
          state_nxt = dru_pkg::DRU_IDLE; // see (RULE2)
      end
      default:
        state_nxt = dru_pkg::DRU_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      state_r <= dru_pkg::DRU_IDLE;
    else
      state_r <= state_nxt;
  end

  // One-cycle incoming and going notifications
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      incoming_r <= 1'b0;
      going_r <= 1'b0;
    end
    else
    begin
      incoming_r <= (state_r == dru_pkg::DRU_IDLE)
        && (state_nxt == dru_pkg::DRU_ACTIVE); // see (RULE1)
      going_r <= (state_r == dru_pkg::DRU_ACTIVE)
        && (state_nxt == dru_pkg::DRU_IDLE); // see (RULE2)
    end
  end

  assign diag_incoming = incoming_r;
  assign diag_going = going_r;

  // Lamp follows the open interrupt window
  assign fault_lamp = (state_r == dru_pkg::DRU_ACTIVE); // see (RULE4)

  // Record flags; frozen against new faults while a window is open
  always_comb
  begin
    if (state_r == dru_pkg::DRU_ACTIVE)
      flags_nxt = flags_r & fault_in; // see (RULE3) (RULE19)
    else
      flags_nxt = fault_in; // see (RULE19)
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      flags_r <= '0;
    else
      flags_r <= flags_nxt;
  end

  // Timestamp caught when a new fault enters the record
  always_ff @(posedge clk)
  begin
    if (!nrst)
      stamp_r <= dru_pkg::RST_STAMP;
    else if (state_r == dru_pkg::DRU_IDLE && new_fault)
      stamp_r <= ticker; // see (RULE17)
  end

  // Field bytes, summaries rebuilt from the remaining flags
  always_comb
  begin
    ch_byte0 = dru_pkg::RST_CHFAULT;
    ch_byte0[dru_pkg::CH_PARAM] = flags_r.param_err; // see (RULE16)
    ch_byte0[dru_pkg::CH_SHORT] = flags_r.exc_short; // see (RULE16)
    ch_byte0[dru_pkg::CH_UNDER] = flags_r.range_under; // see (RULE16)
    ch_byte0[dru_pkg::CH_OVER] = flags_r.range_over; // see (RULE16)
    chmap = dru_pkg::RST_CHMAP;
    chmap[dru_pkg::MAP_CH0] = |ch_byte0; // see (RULE15)
    summary = dru_pkg::RST_SUMMARY;
    summary[dru_pkg::SUM_MOD_FAIL] = flags_r.module_fail; // see (RULE9)
    summary[dru_pkg::SUM_EXT_ERR] = flags_r.ext_err; // see (RULE9)
    summary[dru_pkg::SUM_CH_ERR] = |chmap; // see (RULE9) (RULE19)
    summary[dru_pkg::SUM_AUX] = flags_r.aux_missing; // see (RULE9)
    summary[dru_pkg::SUM_PARAM] = flags_r.param_err; // see (RULE9)
    internal_b = dru_pkg::RST_INTERNAL;
    internal_b[dru_pkg::INT_BUF_OVF] = flags_r.buf_overflow; // see (RULE11)
    internal_b[dru_pkg::INT_COMM] = flags_r.comm_err; // see (RULE11)
  end

  // Record image in byte order
  always_comb
  begin
    rec_bytes[dru_pkg::OFS_SUMMARY] = summary;
    rec_bytes[dru_pkg::OFS_CLASS] = dru_pkg::RST_CLASS; // see (RULE10)
    rec_bytes[dru_pkg::OFS_SPARE] = dru_pkg::RST_SPARE;
    rec_bytes[dru_pkg::OFS_INTERNAL] = internal_b;
    rec_bytes[dru_pkg::OFS_KIND] = dru_pkg::RST_KIND; // see (RULE12)
    rec_bytes[dru_pkg::OFS_BITS] = dru_pkg::RST_BITS; // see (RULE13)
    rec_bytes[dru_pkg::OFS_COUNT] = dru_pkg::RST_COUNT; // see (RULE14)
    rec_bytes[dru_pkg::OFS_CHMAP] = chmap;
    rec_bytes[dru_pkg::OFS_CHFAULT] = ch_byte0;
    for (int i = 1; i < 8; i++)
      rec_bytes[5'(i) + dru_pkg::OFS_CHFAULT] = dru_pkg::RST_CHFAULT;
    for (int i = 0; i < 4; i++)
      rec_bytes[5'(i) + dru_pkg::OFS_STAMP] = stamp_r[8*i +: 8];
  end

  // Selector decode: maps a request onto a record byte offset
  logic [4:0] rd_ofs;
  logic rd_bad;
  logic [7:0] sub_rel;

  always_comb
  begin
    rd_ofs = rd_cmd.byte_sel;
    rd_bad = 1'b0;
    sub_rel = rd_cmd.object_subindex - dru_pkg::SUB_FIRST;
    if (rd_cmd.path == dru_pkg::DRU_PATH_SET)
    begin
      if (rd_cmd.record_set_number == dru_pkg::SET_FULL)
        rd_bad = rd_cmd.byte_sel >= dru_pkg::RECORD_LEN; // see (RULE6)
      else if (rd_cmd.record_set_number == dru_pkg::SET_SHORT)
        rd_bad = rd_cmd.byte_sel >= dru_pkg::SHORT_LEN; // see (RULE6)
      else
        rd_bad = 1'b1;
    end
    else if (rd_cmd.path == dru_pkg::DRU_PATH_CAN)
    begin
      if (rd_cmd.object_index == dru_pkg::IDX_FULL)
        rd_bad = rd_cmd.byte_sel >= dru_pkg::RECORD_LEN; // see (RULE7)
      else if (rd_cmd.object_index == dru_pkg::IDX_SHORT)
        rd_bad = rd_cmd.byte_sel >= dru_pkg::SHORT_LEN; // see (RULE7)
      else
        rd_bad = 1'b1;
    end
    else if (rd_cmd.path == dru_pkg::DRU_PATH_ETH)
    begin
      if (rd_cmd.object_index != dru_pkg::IDX_ETH)
        rd_bad = 1'b1;
      else if (rd_cmd.object_subindex == dru_pkg::SUB_STAMP)
      begin
        rd_ofs = dru_pkg::OFS_STAMP + rd_cmd.byte_sel; // see (RULE8)
        rd_bad = rd_cmd.byte_sel >= 5'h04;
      end
      else if (rd_cmd.object_subindex >= dru_pkg::SUB_FIRST
        && rd_cmd.object_subindex <= dru_pkg::SUB_CHLAST)
      begin
        rd_ofs = sub_rel[4:0]; // see (RULE8)
        rd_bad = rd_cmd.byte_sel != 5'h00;
      end
      else
        rd_bad = 1'b1;
    end
    else
      rd_bad = 1'b1;
  end

  // Registered answer, one cycle after the request
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rd_ack_r <= 1'b0;
      rd_data_r <= 8'h00;
      rd_err_r <= 1'b0;
    end
    else
    begin
      rd_ack_r <= rd_req;
      if (rd_req)
      begin
        rd_err_r <= rd_bad;
        rd_data_r <= rd_bad ? 8'h00 : rec_bytes[rd_ofs]; // see (RULE2)
      end
    end
  end

  assign rd_ack = rd_ack_r;
  assign rd_rsp.data = rd_data_r;
  assign rd_rsp.err = rd_err_r;

endmodule

/* File: dru_diag_record_bench.sv */
// Bench for the diagnostic record unit, reads through the coupler model.
// Assumes a short ticker prescaler to keep the run brief.
module dru_diag_record_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 4;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic en = 1'b0;
  dru_pkg::dru_fault_t flt = '0;
  logic inc, go, lamp, rq, ack;
  dru_pkg::dru_rd_req_t cmd;
  dru_pkg::dru_rd_rsp_t rsp, r;
  logic [31:0] tick, t0, st;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int run = 0;
  int evs [6] = '{6, 4, 3, 5, 1, 0};
  logic [7:0] dflt [10] = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h71,
                            8'h08, 8'h01, 8'h00, 8'h00, 8'h00};

  dru_diag_record #(.CYCLES_PER_US(P)) dut_u (.clk(clk), .nrst(nrst),
    .diag_int_enable(en), .fault_in(flt), .diag_incoming(inc),
    .diag_going(go), .fault_lamp(lamp), .rd_req(rq), .rd_cmd(cmd),
    .rd_ack(ack), .rd_rsp(rsp), .ticker(tick));
  dru_coupler_model cpl_u (.clk(clk), .rd_req(rq), .rd_cmd(cmd),
    .rd_ack(ack), .rd_rsp(rsp));

  always #5 clk = ~clk;

  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk)
  begin
    run <= run + 1;
    cyc <= nrst ? cyc + 1 : 0;
    if (run == 20000)
    begin
      fails = fails + 1;
      finish_test();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic dru_pkg::dru_rd_req_t mk(input logic [2:0] p,
      input logic [15:0] s, input logic [4:0] b);
    mk.path = dru_pkg::dru_path_t'(p);
    mk.record_set_number = s[7:0];
    mk.object_index = (p == 3'b100) ? dru_pkg::IDX_ETH : s;
    mk.object_subindex = s[7:0];
    mk.byte_sel = b;
  endfunction

  task rd(input logic [2:0] p, input logic [15:0] s, input logic [4:0] b,
          input logic [7:0] ed, input logic ee);
    cpl_u.read(mk(p, s, b), r);
    chk("rd_data", {24'h0, ed}, {24'h0, r.data});
    chk("rd_err", {31'h0, ee}, {31'h0, r.err});
  endtask

  // Waits for one pulse; 40 cycles is far above the one-cycle answer
  task wt(input logic g);
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(negedge clk);
      if ((g ? go : inc) === 1'b1)
        break;
    end
    chk(g ? "going" : "incoming", 1, i < 40);
  endtask

  initial
  begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    for (int b = 0; b < 10; b++)
      rd(3'b001, 16'h0001, b[4:0], dflt[b], 1'b0);
    for (int b = 0; b < 10; b++)
      rd(3'b100, 16'h0002 + b[15:0], 5'h00, dflt[b], 1'b0);
    rd(3'b001, 16'h0000, 5'h03, 8'h00, 1'b0);
    rd(3'b001, 16'h0000, 5'h04, 8'h00, 1'b1);
    rd(3'b001, 16'h0002, 5'h00, 8'h00, 1'b1);
    rd(3'b001, 16'h0001, 5'h14, 8'h00, 1'b1);
    rd(3'b010, 16'h2f01, 5'h13, 8'h00, 1'b0);
    rd(3'b010, 16'h2f00, 5'h04, 8'h00, 1'b1);
    rd(3'b100, 16'h0012, 5'h00, 8'h00, 1'b1);
    rd(3'b100, 16'h0013, 5'h04, 8'h00, 1'b1);
    t0 = tick;
    repeat (10 * P) @(negedge clk);
    chk("tick_rate", t0 + 32'd10, tick);
    flt = 9'h19c;
    repeat (20) @(negedge clk);
    chk("lamp_off", 0, lamp);
    rd(3'b001, 16'h0001, 5'h00, 8'h0d, 1'b0);
    rd(3'b001, 16'h0001, 5'h03, 8'h18, 1'b0);
    rd(3'b001, 16'h0001, 5'h07, 8'h01, 1'b0);
    rd(3'b001, 16'h0001, 5'h08, 8'h08, 1'b0);
    flt = '0;
    repeat (3) @(negedge clk);
    rd(3'b001, 16'h0001, 5'h00, 8'h00, 1'b0);
    en = 1'b1;
    flt.range_over = 1'b1;
    t0 = cyc / P;
    wt(1'b0);
    chk("lamp_on", 1, lamp);
    rd(3'b001, 16'h0001, 5'h08, 8'h80, 1'b0);
    rd(3'b001, 16'h0001, 5'h00, 8'h08, 1'b0);
    for (int b = 0; b < 4; b++)
    begin
      cpl_u.read(mk(3'b100, 16'h0013, b[4:0]), r);
      st[8*b +: 8] = r.data;
    end
    chk("stamp_near", 1, (st - t0 + 32'd1) <= 32'd2);
    flt.range_under = 1'b1;
    repeat (3) @(negedge clk);
    rd(3'b001, 16'h0001, 5'h08, 8'h80, 1'b0);
    flt.range_over = 1'b0;
    repeat (3) @(negedge clk);
    rd(3'b001, 16'h0001, 5'h08, 8'h00, 1'b0);
    chk("lamp_held", 1, lamp);
    flt.range_under = 1'b0;
    wt(1'b1);
    chk("lamp_off", 0, lamp);
    for (int k = 0; k < 6; k++)
    begin
      flt[evs[k]] = 1'b1;
      wt(1'b0);
      flt = '0;
      wt(1'b1);
    end
    en = 1'b0;
    flt.aux_missing = 1'b1;
    repeat (10) @(negedge clk);
    chk("lamp_off", 0, lamp);
    rd(3'b001, 16'h0001, 5'h00, 8'h10, 1'b0);
    flt = '0;
    finish_test();
  end
endmodule

/* File: dru_diag_record_props.sv */
// Checker for the diagnostic record unit ports.
// Assumes one clock domain and the synchronous active-low reset.
module dru_diag_record_props #(
  parameter int CYCLES_PER_US = dru_pkg::TICK_CYCLES,
  parameter int NUM_CH_BYTES = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Interrupt side
  input wire logic diag_int_enable,
  input wire logic diag_incoming,
  input wire logic diag_going,
  input wire logic fault_lamp,
  // Read side
  input wire logic rd_req,
  input wire dru_pkg::dru_rd_req_t rd_cmd,
  input wire logic rd_ack,
  input wire dru_pkg::dru_rd_rsp_t rd_rsp,
  input wire logic [dru_pkg::TICKER_W-1:0] ticker
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  AST_ACK: assert property (rd_req |=> rd_ack)
    else $error("read not answered next cycle");
  AST_ACK_ONE: assert property (!rd_req |=> !rd_ack)
    else $error("answer without request");
  AST_RSP_HOLD: assert property (!$past(rd_req) |-> $stable(rd_rsp))
    else $error("answer changed without request");
  AST_ERR_DATA: assert property (rd_ack && rd_rsp.err |-> rd_rsp.data == 8'h00)
    else $error("refused read carries data");
  AST_CAN_SHORT: assert property (rd_req
    && rd_cmd.path == dru_pkg::DRU_PATH_CAN
    && rd_cmd.object_index == dru_pkg::IDX_SHORT
    && rd_cmd.byte_sel > 5'h03 |=> rd_rsp.err)
    else $error("short object read beyond four bytes");
  AST_EN: assert property ($rose(fault_lamp) |-> $past(diag_int_enable))
    else $error("window opened while disabled");
  // Pulses and lamp come from the same edge, so they are seen together
  AST_INC: assert property ($rose(fault_lamp) |-> diag_incoming)
    else $error("no incoming with lamp on");
  AST_INC_SRC: assert property (diag_incoming
    |-> fault_lamp && !$past(fault_lamp))
    else $error("incoming without window start");
  AST_GO: assert property ($fell(fault_lamp) |-> diag_going)
    else $error("no going with lamp off");
  AST_GO_SRC: assert property (diag_going
    |-> !fault_lamp && $past(fault_lamp))
    else $error("going without window end");
  AST_NO_INC_DIS: assert property (!diag_int_enable && !fault_lamp
    |=> !diag_incoming)
    else $error("incoming while interrupts disabled");
  AST_TICK: assert property ($changed(ticker)
    |-> ticker == $past(ticker) + 32'h1)
    else $error("ticker step not one");

  cover property ($rose(fault_lamp));
  cover property (diag_going);
  cover property (rd_ack && rd_rsp.err);
endmodule

bind dru_diag_record dru_diag_record_props #(
  .CYCLES_PER_US(CYCLES_PER_US), .NUM_CH_BYTES(NUM_CH_BYTES)
) chk_u (.clk(clk), .nrst(nrst), .diag_int_enable(diag_int_enable),
  .diag_incoming(diag_incoming), .diag_going(diag_going),
  .fault_lamp(fault_lamp), .rd_req(rd_req), .rd_cmd(rd_cmd),
  .rd_ack(rd_ack), .rd_rsp(rd_rsp), .ticker(ticker));

/* File: dru_pkg.sv */
// Constants and types shared by the diagnostic record unit.
// Assumes a 100 MHz module clock and a synchronous, active-low reset.
// Function
// (RULE1) Interrupts only when enabled by parameter input.
// (RULE2) Incoming gives record; going follows when cleared.
// (RULE3) Events between incoming and going are discarded.
// (RULE4) Fault lamp lit from incoming to going.
// (RULE5) Six listed fault events raise interrupts.
// (RULE6) Record set 01h full, 00h first four.
// (RULE7) Object index 2F01h full, 2F00h first four.
// (RULE8) Index 5005h, subindex 02h to 13h per field.
// (RULE9) Summary bits 0,2,3,4,7 flag module faults.
// (RULE10) Module class byte reads 15h.
// (RULE11) Internal byte bit3 overflow, bit4 communication.
// (RULE12) Channel kind byte reads 71h, analog input.
// (RULE13) Diagnostic bits per channel read 08h.
// (RULE14) Channel count byte reads 01h.
// (RULE15) Channel map bit0 on any channel error.
// (RULE16) Channel byte0 bits 0,3,6,7; rest reserved.
// (RULE17) Timestamp holds ticker value at event.
// (RULE18) Ticker from zero, per microsecond, wraps 32-bit.
// (RULE19) Flags clear when conditions vanish, summaries recomputed.
// (RULE20) Microsecond tick comes from clock prescaler.
package dru_pkg;

  // Clock and ticker timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_US = 1;
  localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int TICKER_W = 32;

  // Record layout, byte offsets
  localparam logic [4:0] OFS_SUMMARY = 5'h00;
  localparam logic [4:0] OFS_CLASS = 5'h01;
  localparam logic [4:0] OFS_SPARE = 5'h02;
  localparam logic [4:0] OFS_INTERNAL = 5'h03;
  localparam logic [4:0] OFS_KIND = 5'h04;
  localparam logic [4:0] OFS_BITS = 5'h05;
  localparam logic [4:0] OFS_COUNT = 5'h06;
  localparam logic [4:0] OFS_CHMAP = 5'h07;
  localparam logic [4:0] OFS_CHFAULT = 5'h08;
  localparam logic [4:0] OFS_STAMP = 5'h10;
  localparam logic [4:0] RECORD_LEN = 5'h14;
  localparam logic [4:0] SHORT_LEN = 5'h04;

  // Reset and fixed values
  localparam logic [7:0] RST_SUMMARY = 8'h00;
  localparam logic [7:0] RST_CLASS = 8'h15;
  localparam logic [7:0] RST_SPARE = 8'h00;
  localparam logic [7:0] RST_INTERNAL = 8'h00;
  localparam logic [7:0] RST_KIND = 8'h71;
  localparam logic [7:0] RST_BITS = 8'h08;
  localparam logic [7:0] RST_COUNT = 8'h01;
  localparam logic [7:0] RST_CHMAP = 8'h00;
  localparam logic [7:0] RST_CHFAULT = 8'h00;
  localparam logic [31:0] RST_STAMP = 32'h0000_0000;

  // Field positions
  localparam int SUM_MOD_FAIL = 0;
  localparam int SUM_EXT_ERR = 2;
  localparam int SUM_CH_ERR = 3;
  localparam int SUM_AUX = 4;
  localparam int SUM_PARAM = 7;
  localparam int INT_BUF_OVF = 3;
  localparam int INT_COMM = 4;
  localparam int CH_PARAM = 0;
  localparam int CH_SHORT = 3;
  localparam int CH_UNDER = 6;
  localparam int CH_OVER = 7;
  localparam int MAP_CH0 = 0;

  // Selectors per access path
  localparam logic [7:0] SET_SHORT = 8'h00;
  localparam logic [7:0] SET_FULL = 8'h01;
  localparam logic [15:0] IDX_SHORT = 16'h2f00;
  localparam logic [15:0] IDX_FULL = 16'h2f01;
  localparam logic [15:0] IDX_ETH = 16'h5005;
  localparam logic [7:0] SUB_FIRST = 8'h02;
  localparam logic [7:0] SUB_CHFAULT = 8'h0a;
  localparam logic [7:0] SUB_CHLAST = 8'h11;
  localparam logic [7:0] SUB_STAMP = 8'h13;

  typedef enum logic [2:0]
  {
    DRU_PATH_SET = 3'b001,
    DRU_PATH_CAN = 3'b010,
    DRU_PATH_ETH = 3'b100
  } dru_path_t;

  typedef enum logic [1:0]
  {
    DRU_IDLE = 2'b01,
    DRU_ACTIVE = 2'b10
  } dru_state_t;

  // Live fault conditions from the measuring front end
  typedef struct packed
  {
    logic module_fail;
    logic ext_err;
    logic aux_missing;
    logic param_err;
    logic buf_overflow;
    logic comm_err;
    logic exc_short;
    logic range_under;
    logic range_over;
  } dru_fault_t;

  // Read request and answer
  typedef struct packed
  {
    dru_path_t path;
    logic [7:0] record_set_number;
    logic [15:0] object_index;
    logic [7:0] object_subindex;
    logic [4:0] byte_sel;
  } dru_rd_req_t;

  typedef struct packed
  {
    logic [7:0] data;
    logic err;
  } dru_rd_rsp_t;

endpackage

/* File: dru_ticker.sv */
// Free-running microsecond ticker with clock prescaler.
// Assumes the module clock period given in the package.
module dru_ticker #(
  parameter int CYCLES_PER_US = dru_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Ticker value
  output logic [dru_pkg::TICKER_W-1:0] ticker
);

  localparam int PW = (CYCLES_PER_US > 1) ? $clog2(CYCLES_PER_US) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(CYCLES_PER_US - 1);

  initial
  begin
    if (CYCLES_PER_US < 1)
      $error("CYCLES_PER_US must be at least one");
  end

  logic [PW-1:0] pre_r;
  logic [dru_pkg::TICKER_W-1:0] ticker_r;

  // Prescaler makes one tick per microsecond exactly
  always_ff @(posedge clk)
  begin
    if (!nrst)
      pre_r <= '0;
    else if (pre_r == PRE_LAST)
      pre_r <= '0; // see (RULE20)
    else
      pre_r <= pre_r + PW'(1);
  end

  // Wraps naturally after the all-ones value
  always_ff @(posedge clk)
  begin
    if (!nrst)
      ticker_r <= '0; // see (RULE18)
    else if (pre_r == PRE_LAST)
      ticker_r <= ticker_r + dru_pkg::TICKER_W'(1); // see (RULE18)
  end

  assign ticker = ticker_r;

endmodule
